// ===== logic/segment_address_translator.sv
// Segment based virtual to physical translator with APB registers
`timescale 1ns/1ps

// Summary of operation
// - User mode with bit 31 set raises error
// - User segment is 2GB from address zero
// - Top bits 100 map to 000, cacheable
// - Top bits 101 map to 000, uncacheable
// - Top bits 11 pass through unchanged
// - User pair 00 becomes 01, 01 becomes 10
// - User segment has four width fields
// - Kernel mapped segment has two width fields
// - Unmapped kernel region has eight width fields
// - Kernel user-segment access translates like user
// - Exception enters kernel; return restores saved mode
// - TLB shutdown flag reads set after reset
// - Width comes from physical bits and map
// - Only top three virtual bits steer translation
// - Physical top bits reveal originating segment, except 100 and 101 both give 000
// - Width fields select 8, 16 or 32 bits
module segment_address_translator (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic req_valid,
   input wire logic [31:0] req_vaddr,
   input wire logic exc_detect,
   input wire logic return_from_exception,
   output logic bus_valid,
   output logic [31:0] bus_paddr,
   output logic bus_cacheable,
   output logic [1:0] bus_width,
   output logic addr_error,
   output logic kernel_mode,
   output logic irq
);

   // Width map register, one 2-bit field per sub-region
   logic [27:0] width_map;
   logic [1:0] width_field [14];
   // Saved previous privilege mode
   logic prev_kernel;
   // Sticky event flags and their mask
   logic [1:0] int_status;
   logic [1:0] int_mask;

   // Next values
   logic [27:0] next_width_map;
   logic [1:0] next_int_status;
   logic [1:0] next_int_mask;
   logic next_kernel;
   logic next_prev_kernel;
   logic next_irq;
   logic next_pready;
   logic next_pslverr;
   logic [31:0] next_prdata;
   logic next_bus_valid;
   logic [31:0] next_bus_paddr;
   logic next_cacheable;
   logic [1:0] next_bus_width;
   logic next_addr_error;
   // Translation intermediates
   logic [31:0] phys;
   logic [3:0] field_idx;
   logic violation;
   // APB phase decode
   logic apb_first;
   logic apb_done;
   logic wr_en;

   // Slice the map into fields so the lookup is a plain index
   genvar gi;
   generate
      for (gi = 0; gi < segment_xlate_pkg::NUM_FIELDS; gi++) begin : g_field
         assign width_field[gi] = width_map[gi*2 +: 2];
      end
   endgenerate

   // First access cycle raises pready; the transfer ends one edge later
   assign apb_first = psel && penable && !pready;
   assign apb_done = psel && penable && pready;
   assign wr_en = apb_done && pwrite;

   // Segment decode and address rewrite
   always_comb begin
      phys = req_vaddr;
      next_cacheable = 1'b1;
      // Only bits 31:29 are looked at, never the rest of the page number
      if (req_vaddr[31:29] == segment_xlate_pkg::SEG_CACHED) begin
         phys[31:29] = segment_xlate_pkg::PA_UNMAPPED;
      end else if (req_vaddr[31:29] == segment_xlate_pkg::SEG_UNCACHED) begin
         phys[31:29] = segment_xlate_pkg::PA_UNMAPPED;
         next_cacheable = 1'b0;
      end else if (!req_vaddr[31]) begin
         // Same rewrite whatever the mode, so kernel sees user mapping
         phys[31:30] = req_vaddr[31:30] +
            segment_xlate_pkg::USEG_STEP;
      end
      // Kernel mapped segment keeps phys equal to the virtual address
      // Kernel addresses are illegal while in user mode
      violation = req_vaddr[31] && !kernel_mode;
   end

   // Pick the width field from the physical region
   always_comb begin
      case (phys[31:29])
         3'h0: field_idx = {1'b0, phys[28:26]};
         3'h2, 3'h3, 3'h4, 3'h5: begin
            field_idx = segment_xlate_pkg::FIELD_USER + {2'h0,
               2'(phys[31:29] - segment_xlate_pkg::PA_USER_BASE)};
         end
         3'h6, 3'h7: begin
            field_idx = segment_xlate_pkg::FIELD_MAPPED +
               {3'h0, phys[29]};
         end
         // Region 001 is never produced
         default: field_idx = 4'h0;
      endcase
      next_bus_width = width_field[field_idx];
      // A refused reference never reaches the bus
      next_bus_valid = req_valid && !violation;
      next_addr_error = req_valid && violation;
      // Address held while idle to keep the bus quiet
      next_bus_paddr = req_valid ? phys : bus_paddr;
   end

   // Translation outputs, one cycle after the request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_valid <= 1'b0;
         bus_paddr <= 32'h0;
         bus_cacheable <= 1'b0;
         bus_width <= segment_xlate_pkg::WIDTH_32;
         addr_error <= 1'b0;
      end else begin
         bus_valid <= next_bus_valid;
         bus_paddr <= next_bus_paddr;
         bus_cacheable <= req_valid ? next_cacheable : bus_cacheable;
         bus_width <= req_valid ? next_bus_width : bus_width;
         addr_error <= next_addr_error;
      end
   end

   // Privilege stack: exception wins over a return in the same cycle
   always_comb begin
      next_kernel = kernel_mode;
      next_prev_kernel = prev_kernel;
      if (exc_detect) begin
         next_kernel = segment_xlate_pkg::PRIV_KERNEL;
         next_prev_kernel = kernel_mode;
      end else if (return_from_exception) begin
         next_kernel = prev_kernel;
         next_prev_kernel = segment_xlate_pkg::PRIV_USER;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         kernel_mode <= segment_xlate_pkg::PRIV_RST;
         prev_kernel <= segment_xlate_pkg::PRIV_RST;
      end else begin
         kernel_mode <= next_kernel;
         prev_kernel <= next_prev_kernel;
      end
   end

   // Register file: writes, sticky flags and read mux
   always_comb begin
      next_width_map = width_map;
      next_int_mask = int_mask;
      next_int_status = int_status;
      if (wr_en && paddr == segment_xlate_pkg::OFF_WIDTH_MAP) begin
         next_width_map = pwdata[27:0];
      end
      if (wr_en && paddr == segment_xlate_pkg::OFF_INT_MASK) begin
         next_int_mask = pwdata[1:0];
      end
      // Write one to clear, applied before sets so a new event survives
      if (wr_en && paddr == segment_xlate_pkg::OFF_INT_STATUS) begin
         next_int_status = int_status & ~pwdata[1:0];
      end
      if (next_addr_error) begin
         next_int_status[segment_xlate_pkg::INT_ADDR_ERR] = 1'b1;
      end
      if (exc_detect) begin
         next_int_status[segment_xlate_pkg::INT_EXC] = 1'b1;
      end
      next_irq = |(next_int_status & next_int_mask);
      // Read data and error are prepared in the first access cycle
      next_pready = apb_first;
      next_pslverr = 1'b0;
      next_prdata = 32'h0;
      if (apb_first) begin
         case (paddr)
            segment_xlate_pkg::OFF_WIDTH_MAP: begin
               next_prdata = {4'h0, width_map};
            end
            segment_xlate_pkg::OFF_STATUS: begin
               // No TLB exists, so the shutdown flag is always set
               next_prdata[segment_xlate_pkg::STAT_TLB_SHUTDOWN] = 1'b1;
               next_prdata[segment_xlate_pkg::STAT_KERNEL] = kernel_mode;
               next_prdata[segment_xlate_pkg::STAT_PREV_KERNEL] = prev_kernel;
            end
            segment_xlate_pkg::OFF_INT_STATUS: begin
               next_prdata = {30'h0, int_status};
            end
            segment_xlate_pkg::OFF_INT_MASK: begin
               next_prdata = {30'h0, int_mask};
            end
            // Unmapped offsets answer with an error and zero data
            default: next_pslverr = 1'b1;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         width_map <= segment_xlate_pkg::WIDTH_MAP_RST;
         int_mask <= segment_xlate_pkg::INT_MASK_RST;
         int_status <= 2'h0;
         irq <= 1'b0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         width_map <= next_width_map;
         int_mask <= next_int_mask;
         int_status <= next_int_status;
         irq <= next_irq;
         pready <= next_pready;
         pslverr <= next_pslverr;
         prdata <= next_prdata;
      end
   end

   // Helper: expected unmapped-kernel width for the request
   logic [1:0] exp_k01_width;
   assign exp_k01_width = width_map[{req_vaddr[28:26], 1'b0} +: 2];

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_user_kernel_error: assert property (
      req_valid && req_vaddr[31] && !kernel_mode |=> addr_error && !bus_valid)
      else $error("user kernel access not refused");
   a_cached_map: assert property (
      req_valid && kernel_mode && req_vaddr[31:29] == 3'h4 |=>
      bus_valid && bus_cacheable && bus_paddr == {3'h0, $past(req_vaddr[28:0])})
      else $error("cached kernel mapping wrong");
   a_uncached_map: assert property (
      req_valid && kernel_mode && req_vaddr[31:29] == 3'h5 |=>
      !bus_cacheable && bus_paddr[31:29] == 3'h0)
      else $error("uncached kernel mapping wrong");
   a_mapped_pass: assert property (
      req_valid && kernel_mode && req_vaddr[31:30] == 2'h3 |=>
      bus_paddr == $past(req_vaddr))
      else $error("mapped kernel address changed");
   a_useg_map: assert property (
      req_valid && !req_vaddr[31] |=> bus_valid && bus_paddr ==
      {2'($past(req_vaddr[31:30]) + 2'h1), $past(req_vaddr[29:0])})
      else $error("user segment mapping wrong");
   a_k01_width: assert property (
      req_valid && kernel_mode && req_vaddr[31:30] == 2'h2 |=>
      bus_width == $past(exp_k01_width))
      else $error("kernel region width wrong");
   a_tlb_flag: assert property (
      apb_done && !pwrite && paddr == 12'h004 |-> prdata[0])
      else $error("tlb shutdown flag clear");
   a_exc_kernel: assert property (
      exc_detect ##1 return_from_exception && !exc_detect |=>
      kernel_mode == $past(kernel_mode, 2))
      else $error("return did not restore mode");
   a_irq_event: assert property (
      req_valid && req_vaddr[31] && !kernel_mode && int_mask[0] |=> irq)
      else $error("address error did not interrupt");

   c_user_error: cover property (addr_error ##1 irq);
   c_exc_return: cover property (exc_detect ##[1:4] return_from_exception);
   c_apb_write: cover property (wr_en && paddr == 12'h000);
endmodule : segment_address_translator

// ===== logic/segment_xlate_pkg.sv
// Constants and types shared by the segment address translator
package segment_xlate_pkg;
   // APB register byte offsets
   localparam int APB_ADDR_W = 12;
   localparam logic [11:0] OFF_WIDTH_MAP = 12'h000;
   localparam logic [11:0] OFF_STATUS = 12'h004;
   localparam logic [11:0] OFF_INT_STATUS = 12'h008;
   localparam logic [11:0] OFF_INT_MASK = 12'h00c;
   // Port width fields: 8 unmapped kernel, 4 user, 2 kernel mapped
   localparam int FIELD_W = 2;
   localparam int NUM_FIELDS = 14;
   localparam int MAP_W = 28;
   localparam logic [3:0] FIELD_USER = 4'h8;
   localparam logic [3:0] FIELD_MAPPED = 4'hc;
   localparam logic [27:0] WIDTH_MAP_RST = 28'haaaaaaa;
   // Port width codes
   localparam logic [1:0] WIDTH_8 = 2'h0;
   localparam logic [1:0] WIDTH_16 = 2'h1;
   localparam logic [1:0] WIDTH_32 = 2'h2;
   // Segment codes in virtual and physical address bits 31:29
   localparam logic [2:0] SEG_CACHED = 3'h4;
   localparam logic [2:0] SEG_UNCACHED = 3'h5;
   localparam logic [2:0] PA_UNMAPPED = 3'h0;
   localparam logic [2:0] PA_USER_BASE = 3'h2;
   localparam logic [1:0] USEG_STEP = 2'h1;
   // Status register bit positions
   localparam int STAT_TLB_SHUTDOWN = 0;
   localparam int STAT_KERNEL = 1;
   localparam int STAT_PREV_KERNEL = 2;
   // Interrupt status bit positions
   localparam int INT_W = 2;
   localparam int INT_ADDR_ERR = 0;
   localparam int INT_EXC = 1;
   localparam logic [1:0] INT_MASK_RST = 2'h0;
   // Privilege modes
   typedef enum logic {
      PRIV_USER = 1'b0,
      PRIV_KERNEL = 1'b1
   } priv_e;
   localparam logic PRIV_RST = 1'b1;
endpackage : segment_xlate_pkg

// ===== tb/bus_side_model.sv
// Bus interface side model that consumes translated references
`timescale 1ns/1ps
module bus_side_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic bus_valid,
   input wire logic [1:0] bus_width,
   input wire logic addr_error,
   output int refs,
   output int beats,
   output logic clash
);
   // Counts references and the beats one word needs at the port width
   // Plain references only: no cache is forced, isolated or swapped here
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         refs <= 0;
         beats <= 0;
         clash <= 1'b0;
      end else begin
         if (bus_valid) begin
            refs <= refs + 1;
            // Narrow ports split a word into several beats
            beats <= (bus_width == 2'h0) ? 4 : (bus_width == 2'h1) ? 2 : 1;
         end
         // A suppressed reference must never reach the bus
         if (bus_valid && addr_error) clash <= 1'b1;
      end
   end
endmodule : bus_side_model

// ===== tb/segment_address_translator_test.sv
// Self-checking bench for the segment address translator
`timescale 1ns/1ps
module segment_address_translator_test;
   // One reference: mode, virtual, physical, cacheable check, error
   typedef struct packed {
      logic k;
      logic [31:0] va;
      logic [31:0] pa;
      logic cc;
      logic c;
      logic err;
   } row_s;
   // Width map with every code used; field i holds i mod 3
   localparam logic [27:0] MAP = 28'h4924924;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, req_vaddr = 32'h0, prdata, bus_paddr, rd;
   logic req_valid = 0, exc_detect = 0, return_from_exception = 0;
   logic er, clash;
   logic pready, pslverr, bus_valid, bus_cacheable, addr_error;
   logic kernel_mode, irq;
   logic [1:0] bus_width;
   int fails = 0, checked = 0, cycles = 0, nref = 0, refs, beats;
   row_s rows [14] = '{
      '{1, 32'h00001234, 32'h40001234, 0, 0, 0},
      '{1, 32'h7ffffffc, 32'hbffffffc, 0, 0, 0},
      '{1, 32'h20000000, 32'h60000000, 0, 0, 0},
      '{1, 32'h80001000, 32'h00001000, 1, 1, 0},
      '{1, 32'h9c000010, 32'h1c000010, 1, 1, 0},
      '{1, 32'ha4000000, 32'h04000000, 1, 0, 0},
      '{1, 32'hb8000000, 32'h18000000, 1, 0, 0},
      '{1, 32'hc0000004, 32'hc0000004, 0, 0, 0},
      '{1, 32'he0000000, 32'he0000000, 0, 0, 0},
      '{0, 32'h20000000, 32'h60000000, 0, 0, 0},
      '{0, 32'h55555555, 32'h95555555, 0, 0, 0},
      '{0, 32'h80000000, 32'h0, 0, 0, 1},
      '{0, 32'hffffffff, 32'h0, 0, 0, 1},
      '{1, 32'h80000000, 32'h00000000, 1, 1, 0}};

   segment_address_translator dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .req_valid(req_valid), .req_vaddr(req_vaddr),
      .exc_detect(exc_detect),
      .return_from_exception(return_from_exception), .bus_valid(bus_valid),
      .bus_paddr(bus_paddr), .bus_cacheable(bus_cacheable),
      .bus_width(bus_width), .addr_error(addr_error),
      .kernel_mode(kernel_mode), .irq(irq));
   bus_side_model far (.pclk(pclk), .presetn(presetn),
      .bus_valid(bus_valid), .bus_width(bus_width),
      .addr_error(addr_error), .refs(refs), .beats(beats), .clash(clash));

   // 250 MHz clock
   always #2 pclk = ~pclk;
   // Hang guard, far above the hundred or so cycles the run needs
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 4000) begin
         fails++;
         stop_test();
      end
   end

   task stop_test;
      $display("TB counts: checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : stop_test
   task cmp32(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         fails++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask : cmp32
   task cmp1(input logic g, input logic e);
      cmp32({31'h0, g}, {31'h0, e});
   endtask : cmp1
   // APB cycle; result in rd and er; ends settled after release
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      // Wait ends when pready is seen high; the hang guard ends it if pready never rises
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      #1;
   endtask : apb
   // One translation request; outputs are looked at one cycle later
   task xl(input logic [31:0] va);
      @(posedge pclk);
      req_valid <= 1;
      req_vaddr <= va;
      @(posedge pclk);
      req_valid <= 0;
      #1;
   endtask : xl
   // Exception pulse when e is one, otherwise a return pulse
   task pulse(input logic e);
      @(posedge pclk);
      exc_detect <= e;
      return_from_exception <= !e;
      @(posedge pclk);
      exc_detect <= 0;
      return_from_exception <= 0;
      #1;
   endtask : pulse
   task settle;
      @(posedge pclk);
      #1;
   endtask : settle
   // Field index from the physical top bits, then the map field
   function automatic logic [1:0] wid(input logic [31:0] pa);
      int i;
      if (pa[31:29] == 3'h0) i = pa[28:26];
      else if (pa[31:30] == 2'h3) i = 12 + pa[29];
      else i = 8 + pa[31:29] - 2;
      return MAP[2*i +: 2];
   endfunction : wid

   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1;
      #1;
      cmp1(kernel_mode, 1);
      cmp32({30'h0, bus_width}, 32'h2);
      apb(0, segment_xlate_pkg::OFF_STATUS, 0);
      cmp32(rd, 32'h7);
      apb(0, 12'h010, 0);
      cmp32({er, rd[30:0]}, 32'h80000000);
      apb(1, segment_xlate_pkg::OFF_WIDTH_MAP, {4'h0, MAP});
      $display("TEST reset done");
      // Ordinary references, both modes, every segment and width code
      foreach (rows[i]) begin
         // A return may only step to the saved mode, so repeat it
         while (rows[i].k !== kernel_mode) pulse(rows[i].k);
         xl(rows[i].va);
         cmp1(addr_error, rows[i].err);
         cmp1(bus_valid, !rows[i].err);
         if (!rows[i].err) begin
            nref++;
            cmp32(bus_paddr, rows[i].pa);
            cmp32({30'h0, bus_width}, {30'h0, wid(rows[i].pa)});
            if (rows[i].cc) cmp1(bus_cacheable, rows[i].c);
         end
      end
      $display("TEST table done");
      // Sticky events, masking and write-one-to-clear
      apb(0, segment_xlate_pkg::OFF_INT_STATUS, 0);
      cmp32(rd, 32'h3);
      cmp1(irq, 0);
      cmp32(refs, nref);
      cmp32(beats, 4);
      apb(1, segment_xlate_pkg::OFF_INT_MASK, 1);
      settle();
      cmp1(irq, 1);
      apb(1, segment_xlate_pkg::OFF_INT_STATUS, 1);
      settle();
      cmp1(irq, 0);
      apb(1, segment_xlate_pkg::OFF_INT_MASK, 3);
      settle();
      cmp1(irq, 1);
      apb(1, segment_xlate_pkg::OFF_INT_STATUS, 2);
      settle();
      cmp1(irq, 0);
      $display("TEST interrupt done");
      // Violation then a legal user access on the very next cycle
      pulse(0);
      @(posedge pclk);
      req_valid <= 1;
      req_vaddr <= 32'h90000000;
      @(posedge pclk);
      req_vaddr <= 32'h10000000;
      #1;
      cmp32({bus_valid, addr_error}, 32'h1);
      @(posedge pclk);
      req_valid <= 0;
      #1;
      cmp32({bus_valid, addr_error}, 32'h2);
      cmp32(bus_paddr, 32'h50000000);
      cmp1(clash, 0);
      $display("TEST back_to_back done");
      // Exception then return on the next cycle, then both at once
      @(posedge pclk);
      exc_detect <= 1;
      @(posedge pclk);
      exc_detect <= 0;
      return_from_exception <= 1;
      #1;
      cmp1(kernel_mode, 1);
      @(posedge pclk);
      return_from_exception <= 0;
      #1;
      cmp1(kernel_mode, 0);
      @(posedge pclk);
      exc_detect <= 1;
      return_from_exception <= 1;
      @(posedge pclk);
      exc_detect <= 0;
      return_from_exception <= 0;
      #1;
      cmp1(kernel_mode, 1);
      apb(0, segment_xlate_pkg::OFF_STATUS, 0);
      cmp32(rd, 32'h3);
      $display("TEST privilege done");
      // Reset in mid-run
      @(posedge pclk);
      presetn <= 0;
      repeat (2) @(posedge pclk);
      presetn <= 1;
      #1;
      cmp1(kernel_mode, 1);
      cmp1(irq, 0);
      apb(0, segment_xlate_pkg::OFF_WIDTH_MAP, 0);
      cmp32(rd, {4'h0, segment_xlate_pkg::WIDTH_MAP_RST});
      $display("TEST second reset done");
      stop_test();
   end
endmodule : segment_address_translator_test
